// ==== rtl/capture_b_pkg.sv ====
// Shared constants and types for the capture channel B control block.
// Assumes a single clock domain and synchronous active-low reset.
`default_nettype none
package capture_b_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int BIT_CHANNEL_RESET = 31;
  localparam int BIT_BLOCK_CAPTURE = 30;
  localparam int BIT_FIELD_INVERT = 20;
  localparam int BIT_VRESET_SELECT = 17;
  localparam int BIT_CAPTURE_ENABLE = 15;
  localparam int BIT_FIELD_TWO_SEL = 5;
  localparam int BIT_FIELD_ONE_SEL = 4;
  // Writable control bits other than bit 31; everything else (reserved and omitted fields) reads 0
  localparam logic [31:0] CONTROL_WMASK = 32'h4012_8030;
  localparam logic [31:0] CONTROL_RESET = 32'h4002_0030;
  // ****************************************************************
  // Status and interrupt bit positions
  // ****************************************************************
  localparam int ST_FIELD_ONE = 0;
  localparam int ST_FIELD_TWO = 1;
  localparam int ST_FRAME = 2;
  localparam int ST_VERTICAL = 3;
  localparam int ST_RESET_DONE = 4;
  localparam int NUM_EVENTS = 5;
  localparam logic [NUM_EVENTS-1:0] EVENTS_ZERO = 5'h00;
  localparam logic [NUM_EVENTS-1:0] FIELD_FLAGS = 5'h07;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic field_one_done;
    logic field_two_done;
    logic frame_done;
    logic vertical_irq;
    logic field_bit;
    logic eav_seen;
    logic eav_v_bit;
    logic vertical_control_input;
  } video_in_type;

  typedef enum logic [1:0] {
    RST_IDLE,
    RST_DRAIN,
    RST_FLUSH
  } reset_state_type;
endpackage : capture_b_pkg
`default_nettype wire

// ==== rtl/capture_b_vertical_line_counter_reset.sv ====
// Produces the vertical line counter reset pulse.
// Assumes EAV codes and the vertical control input are synchronous to the clock.
`default_nettype none
module capture_b_vertical_line_counter_reset
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_select,
  input wire logic i_eav_seen,
  input wire logic i_eav_v_bit,
  input wire logic i_vctl,
  output logic o_reset_pulse
);
  import capture_b_pkg::*;

  logic vprev_q;
  logic vprev_d;
  logic vctl_q;
  logic vctl_d;
  logic eav_edge;
  logic vctl_edge;

  // ****************************************************************
  // Edge detection on V bit and vertical control input
  // ****************************************************************
  always_comb
  begin
    vprev_d = i_eav_seen ? i_eav_v_bit : vprev_q;
    vctl_d = i_vctl;
    // First EAV with V=1 (select 0) or first with V=0 (select 1)
    eav_edge = i_eav_seen && (i_eav_v_bit != vprev_q) && (i_eav_v_bit == !i_select);
    vctl_edge = (i_vctl != vctl_q) && (i_vctl == !i_select);
    o_reset_pulse = eav_edge || vctl_edge;
  end

  // Register previous levels
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      vprev_q <= 1'b0;
      vctl_q <= 1'b0;
    end
    else
    begin
      vprev_q <= vprev_d;
      vctl_q <= vctl_d;
    end
  end
endmodule : capture_b_vertical_line_counter_reset
`default_nettype wire

// ==== rtl/capture_b_resync.sv ====
// Holds capture DMA events off after block capture clears until a frame start.
// Assumes a one-cycle frame start pulse from the field detector.
`default_nettype none
module capture_b_resync
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_block,
  input wire logic i_frame_start,
  output logic o_events_allowed
);
  import capture_b_pkg::*;

  logic wait_q;
  logic wait_d;

  // ****************************************************************
  // Wait for next frame after unblocking
  // ****************************************************************
  always_comb
  begin
    if (i_block)
      wait_d = 1'b1;
    else if (i_frame_start)
      wait_d = 1'b0;
    else
      wait_d = wait_q;
    o_events_allowed = !i_block && !wait_q;
  end

  // Out of reset the block bit is set, so start waiting
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      wait_q <= 1'b1;
    else
      wait_q <= wait_d;
  end
endmodule : capture_b_resync
`default_nettype wire

// ==== rtl/capture_b_control.sv ====
// Control register bank of video capture channel B with status and interrupts.
// Assumes a plain register port, synchronous video indications and one clock.
// Assumes the capture FIFO, DMA engine and field detector live outside it.
// Function
// - Writing 1 to bit 31 starts a channel reset; 0 does nothing.
// - Channel reset waits for pending DMA, then flushes the capture FIFO.
// - Channel reset clears capture enable and restores the control register reset values.
// - While blocked, field and frame complete flags are not set.
// - While blocked, no field, frame or vertical interrupt is raised.
// - After unblocking, DMA events stay off until the next frame start.
// - Field invert selects whether detected 0 means field 1 or 2.
// - Select 0 resets vertical counter at start of vertical blanking.
// - Select 1 resets vertical counter at end of vertical blanking.
// - Reserved bits read zero and ignore writes.
//
// Strobed register access and the address map are this design's own decisions.
`default_nettype none
module capture_b_control
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire capture_b_pkg::bus_req_type I_BUS,
  output logic [31:0] O_RDATA,
  input wire capture_b_pkg::video_in_type I_VIDEO,
  input wire logic I_FRAME_START,
  input wire logic I_DMA_PENDING,
  input wire logic I_FIFO_EMPTY,
  input wire logic I_DMA_EVENT_REQ,
  output logic O_DMA_EVENT,
  output logic O_FIFO_FLUSH,
  output logic O_CAPTURE_ENABLE,
  output logic O_FIELD_IS_TWO,
  output logic O_FIELD_ONE_SEL,
  output logic O_FIELD_TWO_SEL,
  output logic O_VERTICAL_LINE_COUNTER_RESET,
  output logic O_IRQ
);
  import capture_b_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Register bank and read-back
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [NUM_EVENTS-1:0] status_q;
  logic [NUM_EVENTS-1:0] status_d;
  logic [NUM_EVENTS-1:0] mask_q;
  logic [NUM_EVENTS-1:0] mask_d;

  // Status event strobes
  logic [NUM_EVENTS-1:0] set_ev;
  logic [NUM_EVENTS-1:0] clr_ev;

  // Channel reset sequencer
  reset_state_type rst_state_q;
  reset_state_type rst_state_d;

  // Registered outputs
  logic field_two_q;
  logic field_two_d;
  logic dma_event_q;
  logic dma_event_d;
  logic flush_q;
  logic flush_d;

  // Internal control signals
  logic reset_done;
  logic blocked;
  logic events_allowed;
  logic vertical_line_counter_pulse;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // Write strobe decode, one register per address
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (I_BUS.wr)
    begin
      if (I_BUS.addr == ADDR_CONTROL)
        wr_ctrl = 1'b1;
      else if (I_BUS.addr == ADDR_IRQ_STATUS)
        wr_status = 1'b1;
      else if (I_BUS.addr == ADDR_IRQ_MASK)
        wr_mask = 1'b1;
    end
  end

  // Block capture bit gates events, flags and the flush
  assign blocked = ctrl_q[BIT_BLOCK_CAPTURE];

  // ****************************************************************
  // Channel reset sequencer
  // ****************************************************************
  // Wait for pending DMA, flush the FIFO, then restore the register
  always_comb
  begin
    rst_state_d = rst_state_q;
    reset_done = 1'b0;
    case (rst_state_q)
      RST_IDLE:
        if (ctrl_q[BIT_CHANNEL_RESET])
          rst_state_d = RST_DRAIN;
      RST_DRAIN:
        if (!I_DMA_PENDING)
          rst_state_d = RST_FLUSH;
      RST_FLUSH:
        if (I_FIFO_EMPTY)
        begin
          rst_state_d = RST_IDLE;
          reset_done = 1'b1;
        end
      default:
        rst_state_d = RST_IDLE;
    endcase
  end

  // Register the sequencer state
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      rst_state_q <= RST_IDLE;
    else
      rst_state_q <= rst_state_d;
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Next control value from reset completion or a bus write
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (reset_done)
      ctrl_d = CONTROL_RESET;
    else if (wr_ctrl && !ctrl_q[BIT_CHANNEL_RESET])
    begin
      // Reserved bits are masked out of every write
      ctrl_d = I_BUS.wdata & CONTROL_WMASK;
      // Writing 0 never clears a pending reset request
      ctrl_d[BIT_CHANNEL_RESET] = I_BUS.wdata[BIT_CHANNEL_RESET];
      if (I_BUS.wdata[BIT_CHANNEL_RESET])
        ctrl_d[BIT_CAPTURE_ENABLE] = 1'b0;
    end
    else if (wr_ctrl)
    begin
      // During a reset only the block bit may change
      ctrl_d[BIT_BLOCK_CAPTURE] = I_BUS.wdata[BIT_BLOCK_CAPTURE];
    end
  end

  // Register the control bits
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      ctrl_q <= CONTROL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // ****************************************************************
  // Field identity
  // ****************************************************************
  // Detected 0 means field 1 unless invert is set
  always_comb
  begin
    field_two_d = I_VIDEO.field_bit ^ ctrl_q[BIT_FIELD_INVERT];
  end

  // Register the field identity for the capture logic
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      field_two_q <= 1'b0;
    else
      field_two_q <= field_two_d;
  end

  // ****************************************************************
  // DMA event gating
  // ****************************************************************
  // Pass a request only when enabled, unblocked, resynchronised and idle
  always_comb
  begin
    dma_event_d = I_DMA_EVENT_REQ && events_allowed && ctrl_q[BIT_CAPTURE_ENABLE]
      && (rst_state_q == RST_IDLE) && !ctrl_q[BIT_CHANNEL_RESET];
  end

  // Registered event pulse, one cycle after the request
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      dma_event_q <= 1'b0;
    else
      dma_event_q <= dma_event_d;
  end

  // ****************************************************************
  // FIFO flush
  // ****************************************************************
  // Flush while blocked or in the flush step of a channel reset
  always_comb
  begin
    flush_d = blocked || (rst_state_q == RST_FLUSH);
  end

  // Registered flush level
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      flush_q <= 1'b0;
    else
      flush_q <= flush_d;
  end

  // ****************************************************************
  // Interrupt status register
  // ****************************************************************
  // Sticky event bits, cleared by writing ones
  always_comb
  begin
    set_ev = EVENTS_ZERO;
    if (!blocked)
    begin
      set_ev[ST_FIELD_ONE] = I_VIDEO.field_one_done;
      set_ev[ST_FIELD_TWO] = I_VIDEO.field_two_done;
      set_ev[ST_FRAME] = I_VIDEO.frame_done;
      set_ev[ST_VERTICAL] = I_VIDEO.vertical_irq;
    end
    set_ev[ST_RESET_DONE] = reset_done;
    clr_ev = wr_status ? I_BUS.wdata[NUM_EVENTS-1:0] : EVENTS_ZERO;
    // Set wins over a simultaneous clear
    status_d = (status_q & ~clr_ev) | set_ev;
    if (reset_done)
      status_d = (status_q & ~FIELD_FLAGS) | set_ev;
  end

  // Register the sticky status bits
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      status_q <= EVENTS_ZERO;
    else
      status_q <= status_d;
  end

  // ****************************************************************
  // Interrupt mask register
  // ****************************************************************
  // Mask bits follow the status layout
  always_comb
  begin
    mask_d = wr_mask ? I_BUS.wdata[NUM_EVENTS-1:0] : mask_q;
  end

  // Register the mask
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      mask_q <= EVENTS_ZERO;
    else
      mask_q <= mask_d;
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  // Select the addressed register; zero outside a read
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (I_BUS.rd)
    begin
      if (I_BUS.addr == ADDR_CONTROL)
      begin
        rdata_d = ctrl_q & CONTROL_WMASK;
        // The reset request reads back 1 until the sequence finishes
        rdata_d[BIT_CHANNEL_RESET] = ctrl_q[BIT_CHANNEL_RESET];
      end
      else if (I_BUS.addr == ADDR_STATUS)
        rdata_d = {27'h0000000, rst_state_q != RST_IDLE, !events_allowed, blocked,
                   field_two_q, ctrl_q[BIT_CAPTURE_ENABLE]};
      else if (I_BUS.addr == ADDR_IRQ_STATUS)
        rdata_d = {27'h0000000, status_q};
      else if (I_BUS.addr == ADDR_IRQ_MASK)
        rdata_d = {27'h0000000, mask_q};
      else
        rdata_d = 32'h0000_0000;
    end
  end

  // Read data stands in the cycle after the strobe
  always_ff @(posedge I_CLK)
  begin
    if (!I_NRST)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Holds events off after unblocking until a frame start
  capture_b_resync u_resync
  (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_block(blocked),
    .i_frame_start(I_FRAME_START),
    .o_events_allowed(events_allowed)
  );

  // Picks the vertical counter reset point
  capture_b_vertical_line_counter_reset u_vreset
  (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_select(ctrl_q[BIT_VRESET_SELECT]),
    .i_eav_seen(I_VIDEO.eav_seen),
    .i_eav_v_bit(I_VIDEO.eav_v_bit),
    .i_vctl(I_VIDEO.vertical_control_input),
    .o_reset_pulse(vertical_line_counter_pulse)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_RDATA = rdata_q;
  assign O_DMA_EVENT = dma_event_q;
  assign O_FIFO_FLUSH = flush_q;
  assign O_CAPTURE_ENABLE = ctrl_q[BIT_CAPTURE_ENABLE];
  assign O_FIELD_IS_TWO = field_two_q;
  assign O_FIELD_ONE_SEL = ctrl_q[BIT_FIELD_ONE_SEL];
  assign O_FIELD_TWO_SEL = ctrl_q[BIT_FIELD_TWO_SEL];
  assign O_VERTICAL_LINE_COUNTER_RESET = vertical_line_counter_pulse;
  // Level interrupt from any unmasked sticky bit
  assign O_IRQ = |(status_q & mask_q);
endmodule : capture_b_control
`default_nettype wire

// ==== verif/capture_b_control_monitor.sv ====
// Port-level assertion checker for the capture channel B control block.
// Assumes one clock, synchronous active-low reset, bound to the design top.
`default_nettype none
module capture_b_control_monitor
  import capture_b_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire capture_b_pkg::bus_req_type I_BUS,
  input wire logic [31:0] O_RDATA,
  input wire capture_b_pkg::video_in_type I_VIDEO,
  input wire logic I_FRAME_START,
  input wire logic I_DMA_PENDING,
  input wire logic I_FIFO_EMPTY,
  input wire logic I_DMA_EVENT_REQ,
  input wire logic O_DMA_EVENT,
  input wire logic O_FIFO_FLUSH,
  input wire logic O_CAPTURE_ENABLE,
  input wire logic O_FIELD_IS_TWO,
  input wire logic O_FIELD_ONE_SEL,
  input wire logic O_FIELD_TWO_SEL,
  input wire logic O_VERTICAL_LINE_COUNTER_RESET,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  AST_DMA_CAUSE: assert property (O_DMA_EVENT |-> $past(I_DMA_EVENT_REQ))
    else $error("DMA event without a request");
  AST_FLUSH_NO_DMA: assert property ($past(O_FIFO_FLUSH) && O_FIFO_FLUSH |-> !O_DMA_EVENT)
    else $error("DMA event while flushing");
  AST_RESET_VALUES: assert property (disable iff (1'b0) !I_NRST |=>
    !O_IRQ && !O_CAPTURE_ENABLE && O_FIELD_ONE_SEL && O_FIELD_TWO_SEL)
    else $error("Outputs wrong after reset");
  AST_RESET_ENABLE: assert property (I_BUS.wr && I_BUS.addr == ADDR_CONTROL &&
    I_BUS.wdata[BIT_CHANNEL_RESET] |=> !O_CAPTURE_ENABLE [*2])
    else $error("Capture enable kept during channel reset");
  AST_VRESET_CAUSE: assert property (O_VERTICAL_LINE_COUNTER_RESET |->
    I_VIDEO.eav_seen || $changed(I_VIDEO.vertical_control_input))
    else $error("Vertical counter reset without cause");
  AST_RDATA_RESERVED: assert property ($past(I_BUS.rd) && $past(I_BUS.addr) == ADDR_CONTROL
    |-> (O_RDATA & ~CONTROL_WMASK & 32'h7FFF_FFFF) == 32'h0000_0000)
    else $error("Reserved control bits read nonzero");
  AST_RDATA_IDLE: assert property (!$past(I_BUS.rd) |-> O_RDATA == 32'h0000_0000)
    else $error("Read data outside read cycle");
  AST_FLUSH_WAITS_DMA: assert property ($rose(O_FIFO_FLUSH) |->
    !$past(I_DMA_PENDING, 2) || $past(I_BUS.wr, 2))
    else $error("Flush started with DMA pending");
endmodule : capture_b_control_monitor
bind capture_b_control capture_b_control_monitor mon_u (.I_CLK, .I_NRST, .I_BUS, .O_RDATA,
  .I_VIDEO, .I_FRAME_START, .I_DMA_PENDING, .I_FIFO_EMPTY, .I_DMA_EVENT_REQ, .O_DMA_EVENT,
  .O_FIFO_FLUSH, .O_CAPTURE_ENABLE, .O_FIELD_IS_TWO, .O_FIELD_ONE_SEL, .O_FIELD_TWO_SEL,
  .O_VERTICAL_LINE_COUNTER_RESET, .O_IRQ);
`default_nettype wire

// ==== verif/capture_b_control_tb.sv ====
// Self-checking bench for the capture channel B control block.
// Assumes the package, the design and the bound checker compile first.
`default_nettype none
module capture_b_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_b_pkg::*;
  logic clk, nrst, dma_pend, fifo_empty, dma_req, frame_start;
  bus_req_type bus;
  video_in_type vid;
  logic [31:0] rdata;
  logic dma_evt, flush, cap_en, is_two, f1_sel, f2_sel, vc_rst, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Device under test
  capture_b_control dut_u (.I_CLK(clk), .I_NRST(nrst), .I_BUS(bus), .O_RDATA(rdata),
    .I_VIDEO(vid), .I_FRAME_START(frame_start), .I_DMA_PENDING(dma_pend),
    .I_FIFO_EMPTY(fifo_empty), .I_DMA_EVENT_REQ(dma_req), .O_DMA_EVENT(dma_evt),
    .O_FIFO_FLUSH(flush), .O_CAPTURE_ENABLE(cap_en), .O_FIELD_IS_TWO(is_two),
    .O_FIELD_ONE_SEL(f1_sel), .O_FIELD_TWO_SEL(f2_sel), .O_VERTICAL_LINE_COUNTER_RESET(vc_rst), .O_IRQ(irq));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd
  task dma(input logic exp);
    @(posedge clk);
    dma_req <= 1'b1;
    @(posedge clk);
    dma_req <= 1'b0;
    @(negedge clk);
    chk(dma_evt, exp);
  endtask : dma
  task vstep(input logic eav, input logic v, input logic c, input logic exp);
    @(posedge clk);
    vid.eav_seen <= eav;
    vid.eav_v_bit <= v;
    vid.vertical_control_input <= c;
    @(negedge clk);
    chk(vc_rst, exp);
    @(posedge clk);
    vid.eav_seen <= 1'b0;
  endtask : vstep
  task summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    nrst = 1'b0;
    bus = '0;
    vid = '0;
    dma_pend = 1'b0;
    fifo_empty = 1'b0;
    dma_req = 1'b0;
    frame_start = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_CONTROL, CONTROL_RESET);
    chk(f1_sel & f2_sel & ~cap_en, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h0000_001F);
    @(posedge clk);
    vid <= video_in_type'(8'hF0);
    @(posedge clk);
    vid <= '0;
    rd(ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(irq, 1'b0);
    chk(flush, 1'b1);
    dma(1'b0);
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_CONTROL, {2'b01, 12'h000, s[0], 17'h00000});
      vstep(1'b1, s[0], s[0], 1'b0);
      vstep(1'b1, !s[0], s[0], 1'b1);
      vstep(1'b1, !s[0], s[0], 1'b0);
      vstep(1'b0, !s[0], !s[0], 1'b1);
    end
    for (int f = 0; f < 2; f++)
    begin
      wr(ADDR_CONTROL, {11'h200, f[0], 20'h00000});
      repeat (2) @(negedge clk);
      chk(is_two, f[0]);
    end
    wr(ADDR_CONTROL, 32'h7FFF_FFFF);
    rd(ADDR_CONTROL, CONTROL_WMASK);
    chk(cap_en, 1'b1);
    wr(ADDR_CONTROL, 32'h0012_8030);
    wr(ADDR_IRQ_STATUS, 32'h0000_001F);
    chk(flush, 1'b0);
    dma(1'b0);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    dma(1'b1);
    @(posedge clk);
    vid.field_one_done <= 1'b1;
    @(posedge clk);
    vid.field_one_done <= 1'b0;
    rd(ADDR_IRQ_STATUS, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    @(negedge clk);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000);
    @(posedge clk);
    dma_pend <= 1'b1;
    wr(ADDR_CONTROL, 32'h8012_8030);
    rd(ADDR_CONTROL, 32'h8012_0030);
    chk(flush, 1'b0);
    @(posedge clk);
    dma_pend <= 1'b0;
    repeat (8) if (!flush) @(negedge clk);
    chk(flush, 1'b1);
    @(posedge clk);
    fifo_empty <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_IRQ_STATUS, 32'h0000_0010);
    summarize();
  end
endmodule : capture_b_control_tb
`default_nettype wire
